// ---- hw/crc_dbg_pkg.sv ----
// Notes on behaviour
// RULE1: Writing checksum byte one starts a 32-bit checksum of all program memory.
// RULE2: The whole-memory checksum starts at address 0x0000 and runs to the end.
// RULE3: The 32-bit result lands in bytes three (most significant) down to zero.
// RULE4: Debug traffic happens only while halted, with peripherals and program stalled.
// RULE5: While halted the debug port borrows the clock/reset pin and data pin.
// RULE6: Writing checksum byte zero starts a 16-bit checksum of one 256-byte block.
// RULE7: The written byte is the upper start address; the lower byte is 0x00.
// RULE8: The 16-bit block result lands in byte one (high) and byte zero (low).
// RULE9: The adapter waits for a checksum to finish before reading or restarting.
package crc_dbg_pkg;
   localparam logic [7:0] OFS_BYTE_ZERO = 8'ha9;
   localparam logic [7:0] OFS_BYTE_ONE = 8'haa;
   localparam logic [7:0] OFS_BYTE_TWO = 8'hab;
   localparam logic [7:0] OFS_BYTE_THREE = 8'hac;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [15:0] FULL_START_ADDR = 16'h0000;
   localparam logic [7:0] BLOCK_LOW_ADDR = 8'h00;
   localparam logic [7:0] BLOCK_LAST_LOW = 8'hff;
   localparam int BLOCK_BYTES = 256;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_TAKE = 3'b100
   } crc_state_t;
endpackage

// ---- hw/crc_byte_step.sv ----
`timescale 1ns/1ns
// One byte folded into a checksum, most significant bit first.
module crc_byte_step #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] POLY = '1
) (
   // Running value and new byte.
   input wire logic [WIDTH-1:0] crcIn,
   input wire logic [7:0] dataIn,
   // Updated value.
   output logic [WIDTH-1:0] crcOut
);
   // Eight shift steps unrolled by the loop; purely combinational.
   always_comb
   begin
      logic [WIDTH-1:0] c;
      c = crcIn;
      for (int i = 7; i >= 0; i--)
      begin
         if (c[WIDTH-1] ^ dataIn[i])
            c = {c[WIDTH-2:0], 1'b0} ^ POLY;
         else
            c = {c[WIDTH-2:0], 1'b0};
      end
      crcOut = c;
   end
endmodule // crc_byte_step

// ---- hw/program_memory_crc_debug_regs.sv ----
`timescale 1ns/1ns
module program_memory_crc_debug_regs #(
   parameter int PROG_BYTES = 8192,
   parameter logic [31:0] POLY32 = 32'h04c11db7,
   parameter logic [15:0] POLY16 = 16'h1021,
   parameter logic [31:0] INIT32 = 32'h00000000,
   parameter logic [15:0] INIT16 = 16'h0000
) (
   // Clock, reset and freeze.
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Halt control from the device control logic.
   input wire logic haltRequest,
   output logic coreStall_q,
   // Register access from the debug port framing logic.
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata_q,
   output logic crcBusy_q,
   // Program memory read port, data valid the cycle after the read.
   output logic [15:0] memAddr_q,
   output logic memReadEn_q,
   input wire logic [7:0] memRdata,
   // Shared pins.
   input wire logic debugClockPinIn,
   input wire logic debugDataPinIn,
   output logic debugDataPinOut_q,
   output logic debugDataPinOe_q,
   // Debug port side of the shared pins.
   input wire logic debugDataOut,
   input wire logic debugDataOe,
   output logic debugDataIn_q,
   output logic debugClockRise_q,
   // User side of the shared pins.
   input wire logic userDataOut,
   input wire logic userDataOe,
   output logic userDataIn_q,
   output logic userResetN_q
);
   import crc_dbg_pkg::*;
   localparam logic [15:0] PROG_LAST = 16'(PROG_BYTES - 1);
   crc_state_t state_q;
   logic fullMode_q;
   logic [15:0] lastAddr_q;
   logic [31:0] crc32_q;
   logic [15:0] crc16_q;
   logic [31:0] crc32Next;
   logic [15:0] crc16Next;
   logic [7:0] byte0_q, byte1_q, byte2_q, byte3_q;
   logic [SYNC_STAGES-1:0] clkSync_q, dataSync_q;
   logic clkPrev_q;
   logic wrIdle;
   logic lastByte;
   // Accesses count only while halted; a busy engine ignores writes.
   assign wrIdle = ce && regWrite && coreStall_q && (state_q == ST_IDLE);
   assign lastByte = (memAddr_q == lastAddr_q);
   crc_byte_step #(.WIDTH(32), .POLY(POLY32)) step32 (
      .crcIn(crc32_q),
      .dataIn(memRdata),
      .crcOut(crc32Next)
   );
   crc_byte_step #(.WIDTH(16), .POLY(POLY16)) step16 (
      .crcIn(crc16_q),
      .dataIn(memRdata),
      .crcOut(crc16Next)
   );
   // Halt follows the control logic; the stall output freezes core and peripherals.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         coreStall_q <= 1'b0;
      else if (ce)
         coreStall_q <= haltRequest; // RULE4
   end

   // Pin synchronisers; only the last stage is read by logic.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clkSync_q <= '1;
         dataSync_q <= '0;
         clkPrev_q <= 1'b1;
      end
      else if (ce)
      begin
         clkSync_q <= {clkSync_q[SYNC_STAGES-2:0], debugClockPinIn};
         dataSync_q <= {dataSync_q[SYNC_STAGES-2:0], debugDataPinIn};
         clkPrev_q <= clkSync_q[SYNC_STAGES-1];
      end
   end

   // Pin sharing: while halted the debug port owns both pins and the reset
   // meaning of the clock pin is masked, so debug clocking cannot reset the user.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         debugDataPinOut_q <= 1'b0;
         debugDataPinOe_q <= 1'b0;
         debugDataIn_q <= 1'b0;
         userDataIn_q <= 1'b0;
         debugClockRise_q <= 1'b0;
         userResetN_q <= 1'b1;
      end
      else if (ce)
      begin
         if (coreStall_q)
         begin
            debugDataPinOut_q <= debugDataOut; // RULE5
            debugDataPinOe_q <= debugDataOe; // RULE5
            debugDataIn_q <= dataSync_q[SYNC_STAGES-1];
            debugClockRise_q <= clkSync_q[SYNC_STAGES-1] && !clkPrev_q;
            userResetN_q <= 1'b1; // RULE5
         end
         else
         begin
            debugDataPinOut_q <= userDataOut;
            debugDataPinOe_q <= userDataOe;
            userDataIn_q <= dataSync_q[SYNC_STAGES-1];
            debugClockRise_q <= 1'b0;
            userResetN_q <= clkSync_q[SYNC_STAGES-1];
         end
      end
   end

   // Sequencer: one read cycle and one fold cycle per byte, which keeps the
   // memory port simple at the cost of half the possible throughput.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         fullMode_q <= 1'b0;
         lastAddr_q <= 16'h0000;
         memAddr_q <= 16'h0000;
         memReadEn_q <= 1'b0;
         crcBusy_q <= 1'b0;
         crc32_q <= 32'h00000000;
         crc16_q <= 16'h0000;
      end
      else if (ce)
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (wrIdle && regAddr == OFS_BYTE_ONE)
               begin
                  fullMode_q <= 1'b1; // RULE1
                  memAddr_q <= FULL_START_ADDR; // RULE2
                  lastAddr_q <= PROG_LAST; // RULE2
                  crc32_q <= INIT32;
                  memReadEn_q <= 1'b1;
                  crcBusy_q <= 1'b1;
                  state_q <= ST_READ;
               end
               else if (wrIdle && regAddr == OFS_BYTE_ZERO)
               begin
                  fullMode_q <= 1'b0; // RULE6
                  memAddr_q <= {regWdata, BLOCK_LOW_ADDR}; // RULE7
                  lastAddr_q <= {regWdata, BLOCK_LAST_LOW}; // RULE6
                  crc16_q <= INIT16;
                  memReadEn_q <= 1'b1;
                  crcBusy_q <= 1'b1;
                  state_q <= ST_READ;
               end
            end
            ST_READ:
            begin
               memReadEn_q <= 1'b0;
               state_q <= ST_TAKE;
            end
            ST_TAKE:
            begin
               if (fullMode_q)
                  crc32_q <= crc32Next; // RULE1
               else
                  crc16_q <= crc16Next; // RULE6
               if (lastByte)
               begin
                  crcBusy_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
               else
               begin
                  memAddr_q <= memAddr_q + 16'h0001;
                  memReadEn_q <= 1'b1;
                  state_q <= ST_READ;
               end
            end
            default:
            begin
               memReadEn_q <= 1'b0;
               crcBusy_q <= 1'b0;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Result bytes: plain storage when idle, overwritten when a checksum ends.
   // A write of byte zero or one also starts a run, so its stored value is transient.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         byte0_q <= RESULT_RESET;
         byte1_q <= RESULT_RESET;
         byte2_q <= RESULT_RESET;
         byte3_q <= RESULT_RESET;
      end
      else if (ce)
      begin
         if (state_q == ST_TAKE && lastByte)
         begin
            if (fullMode_q)
               {byte3_q, byte2_q, byte1_q, byte0_q} <= crc32Next; // RULE3
            else
               {byte1_q, byte0_q} <= crc16Next; // RULE8
         end
         else if (wrIdle)
         begin
            case (regAddr)
               OFS_BYTE_ZERO: byte0_q <= regWdata;
               OFS_BYTE_ONE: byte1_q <= regWdata;
               OFS_BYTE_TWO: byte2_q <= regWdata;
               OFS_BYTE_THREE: byte3_q <= regWdata;
               default: ;
            endcase
         end
      end
   end

   // Read data; unmapped offsets return zero. Reads mid-run show stale bytes.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         regRdata_q <= 8'h00;
      else if (ce && regRead && coreStall_q)
      begin
         case (regAddr)
            OFS_BYTE_ZERO: regRdata_q <= byte0_q;
            OFS_BYTE_ONE: regRdata_q <= byte1_q;
            OFS_BYTE_TWO: regRdata_q <= byte2_q;
            OFS_BYTE_THREE: regRdata_q <= byte3_q;
            default: regRdata_q <= 8'h00;
         endcase
      end
   end

   property p_full_start;
      @(posedge sys_clk) disable iff (!rst_n)
      wrIdle && regAddr == OFS_BYTE_ONE |=> crcBusy_q && fullMode_q && memAddr_q == 16'h0000 && memReadEn_q;
   endproperty
   a_full_start: assert property (p_full_start) else $error("full checksum did not start at zero"); // RULE1
   property p_full_walk;
      @(posedge sys_clk) disable iff (!rst_n)
      $past(ce) && $past(state_q == ST_TAKE) && !$past(lastByte) |-> memAddr_q == $past(memAddr_q) + 16'h0001;
   endproperty
   a_full_walk: assert property (p_full_walk) else $error("address did not advance by one"); // RULE2
   property p_full_result;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(crcBusy_q) && fullMode_q |-> {byte3_q, byte2_q, byte1_q, byte0_q} == crc32_q;
   endproperty
   a_full_result: assert property (p_full_result) else $error("32-bit result bytes wrong"); // RULE3
   property p_stall;
      @(posedge sys_clk) disable iff (!rst_n)
      $past(ce) |-> coreStall_q == $past(haltRequest);
   endproperty
   a_stall: assert property (p_stall) else $error("stall does not follow halt"); // RULE4
   property p_pin_borrow;
      @(posedge sys_clk) disable iff (!rst_n)
      $past(ce) && $past(coreStall_q) |-> userResetN_q && debugDataPinOe_q == $past(debugDataOe);
   endproperty
   a_pin_borrow: assert property (p_pin_borrow) else $error("pins not handed to debug port"); // RULE5
   property p_block_start;
      @(posedge sys_clk) disable iff (!rst_n)
      wrIdle && regAddr == OFS_BYTE_ZERO |=> !fullMode_q && memAddr_q == {$past(regWdata), 8'h00};
   endproperty
   a_block_start: assert property (p_block_start) else $error("block start address wrong"); // RULE7
   property p_block_page;
      @(posedge sys_clk) disable iff (!rst_n)
      crcBusy_q && !fullMode_q && $past(crcBusy_q) |-> memAddr_q[15:8] == $past(memAddr_q[15:8]);
   endproperty
   a_block_page: assert property (p_block_page) else $error("block checksum left its 256-byte page"); // RULE6
   property p_block_result;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(crcBusy_q) && !fullMode_q |-> {byte1_q, byte0_q} == crc16_q && byte3_q == $past(byte3_q);
   endproperty
   a_block_result: assert property (p_block_result) else $error("16-bit result bytes wrong"); // RULE8
   property p_read_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      $past(ce) && $past(memReadEn_q) |-> !memReadEn_q;
   endproperty
   a_read_pulse: assert property (p_read_pulse) else $error("memory read held for two cycles"); // RULE2
endmodule // program_memory_crc_debug_regs

// ---- sim/crc_far_model.sv ----
`timescale 1ns/1ns
// Far side: the program memory and the adapter's clock pin.
module crc_far_model (
   // Memory port.
   input wire logic sys_clk,
   input wire logic [15:0] memAddr,
   input wire logic memReadEn,
   output logic [7:0] memRdata,
   // Adapter clock pin.
   input wire logic frameOn,
   output logic clkPin
);
   initial memRdata = 8'h00;
   initial clkPin = 1'h1;
   // Data is valid only the cycle after a read; otherwise it flips so a stale byte is caught.
   always @(posedge sys_clk)
      if (memReadEn)
         memRdata <= memAddr[7:0] ^ {memAddr[12:8], 3'h5};
      else
         memRdata <= ~memRdata;
   // The clock pin idles high, so the shared reset stays released, and toggles only in frames.
   always #80 clkPin = frameOn ? ~clkPin : 1'h1;
endmodule // crc_far_model

// ---- sim/program_memory_crc_debug_regs_tb.sv ----
`timescale 1ns/1ns
module program_memory_crc_debug_regs_tb;
   import crc_dbg_pkg::*;
   localparam int PB = 16;
   logic sys_clk = 1'h0, rst_n = 1'h0, ce = 1'h1, halt = 1'h0, regWrite = 1'h0, regRead = 1'h0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata_q, memRdata;
   logic coreStall_q, crcBusy_q, memReadEn_q, frameOn = 1'h0, clkPin, pinLvl;
   logic [15:0] memAddr_q, firstAddr;
   logic dOut_q, dOe_q, dbgIn_q, rise_q, usrIn_q, usrRst_q;
   logic dbgOut = 1'h1, dbgOe = 1'h0, usrOut = 1'h0, usrOe = 1'h0;
   logic [31:0] c32, exp32;
   int failures = 0, checks_done = 0, rdCount = 0, rises = 0, lowSeen = 0;

   always #10 sys_clk = ~sys_clk;
   // The data pin has a pull-up, so nobody driving reads high.
   assign pinLvl = dOe_q ? dOut_q : 1'h1;

   crc_far_model far_u (.sys_clk(sys_clk), .memAddr(memAddr_q), .memReadEn(memReadEn_q),
      .memRdata(memRdata), .frameOn(frameOn), .clkPin(clkPin));

   program_memory_crc_debug_regs #(.PROG_BYTES(PB)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .ce(ce), .haltRequest(halt), .coreStall_q(coreStall_q), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
      .crcBusy_q(crcBusy_q), .memAddr_q(memAddr_q), .memReadEn_q(memReadEn_q),
      .memRdata(memRdata), .debugClockPinIn(clkPin), .debugDataPinIn(pinLvl),
      .debugDataPinOut_q(dOut_q), .debugDataPinOe_q(dOe_q), .debugDataOut(dbgOut),
      .debugDataOe(dbgOe), .debugDataIn_q(dbgIn_q), .debugClockRise_q(rise_q),
      .userDataOut(usrOut), .userDataOe(usrOe), .userDataIn_q(usrIn_q), .userResetN_q(usrRst_q));

   // Monitors: first read address, read count, clock rises and user reset pulses.
   always @(posedge sys_clk)
   begin
      if (memReadEn_q && rdCount == 0)
         firstAddr = memAddr_q;
      if (memReadEn_q)
         rdCount++;
      if (rise_q)
         rises++;
      if (!usrRst_q)
         lowSeen++;
   end

   task automatic print_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Every driver change lands 1 ns after a rising edge.
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      regAddr = a;
      regRead = 1'h1;
      tick(1);
      regRead = 1'h0;
      v = regRdata_q;
      // One idle cycle so that a following call never raises the strobe in the same time step.
      tick(1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'h1;
      tick(1);
      regWrite = 1'h0;
      // One idle cycle so that a following call never raises the strobe in the same time step.
      tick(1);
   endtask

   // Starts a checksum and waits, bounded, for it to finish before anything else.
   task automatic run(input logic [7:0] a, input logic [7:0] d);
      int n;
      rdCount = 0;
      n = 0;
      wr(a, d);
      chk("busy", 1, crcBusy_q);
      while (crcBusy_q !== 1'h0 && n < 2000)
      begin
         tick(1);
         n++;
      end
      if (n == 2000)
      begin
         failures++;
         print_verdict();
      end
   endtask

   // Reference checksum step, most significant bit first, top bit index m.
   function automatic logic [31:0] step(logic [31:0] c, logic [7:0] d, logic [31:0] p, int m);
      logic fb;
      for (int i = 7; i >= 0; i--)
      begin
         fb = c[m] ^ d[i];
         c = c << 1;
         if (fb)
            c = c ^ p;
      end
      return m == 15 ? c & 32'h0000ffff : c;
   endfunction

   function automatic logic [7:0] memByte(logic [15:0] a);
      return a[7:0] ^ {a[12:8], 3'h5};
   endfunction

   initial
   begin
      logic [7:0] v;
      tick(2);
      rst_n = 1'h1;
      halt = 1'h1;
      tick(2);
      chk("stall", 1, coreStall_q);
      for (int a = 'ha9; a <= 'hac; a++)
      begin
         rd(a[7:0], v);
         chk("resetval", RESULT_RESET, v);
      end
      rd(8'hb0, v);
      chk("unmapped", 0, v);
      wr(OFS_BYTE_THREE, 8'h5c);
      rd(OFS_BYTE_THREE, v);
      chk("rw", 8'h5c, v);
      run(OFS_BYTE_ONE, 8'h00);
      chk("first", FULL_START_ADDR, firstAddr);
      chk("count", PB, rdCount);
      exp32 = 32'h00000000;
      for (int a = 0; a < PB; a++)
         exp32 = step(exp32, memByte(a[15:0]), 32'h04c11db7, 31);
      for (int b = 0; b < 4; b++)
      begin
         rd(OFS_BYTE_ZERO + b[7:0], v);
         chk("crc32", exp32[8*b +: 8], v);
      end
      c32 = exp32;
      run(OFS_BYTE_ZERO, 8'h12);
      chk("blockfirst", 16'h1200, firstAddr);
      chk("blockcount", BLOCK_BYTES, rdCount);
      exp32 = 32'h00000000;
      for (int a = 0; a < BLOCK_BYTES; a++)
         exp32 = step(exp32, memByte({8'h12, a[7:0]}), 32'h00001021, 15);
      for (int b = 0; b < 4; b++)
      begin
         rd(OFS_BYTE_ZERO + b[7:0], v);
         chk("crc16", b < 2 ? exp32[8*b +: 8] : c32[8*b +: 8], v);
      end
      // Halted: the debug side owns both pins and the reset stays released.
      dbgOe = 1'h1;
      dbgOut = 1'h0;
      usrOe = 1'h1;
      usrOut = 1'h1;
      rises = 0;
      lowSeen = 0;
      frameOn = 1'h1;
      tick(32);
      frameOn = 1'h0;
      tick(10);
      chk("rises", 4, rises);
      chk("resetheld", 0, lowSeen);
      chk("dbgpin", 0, pinLvl);
      chk("dbgin", 0, dbgIn_q);
      // Running: user owns the pins and register accesses are refused.
      halt = 1'h0;
      rises = 0;
      tick(3);
      chk("run", 0, coreStall_q);
      wr(OFS_BYTE_THREE, 8'h77);
      frameOn = 1'h1;
      tick(32);
      frameOn = 1'h0;
      tick(10);
      chk("userreset", 1, lowSeen > 0);
      chk("norise", 0, rises);
      chk("userpin", 1, pinLvl);
      chk("userin", 1, usrIn_q);
      halt = 1'h1;
      tick(3);
      rd(OFS_BYTE_THREE, v);
      chk("refused", c32[31:24], v);
      // With the clock enable low a write must leave the stored byte untouched.
      ce = 1'h0;
      wr(OFS_BYTE_TWO, 8'h33);
      ce = 1'h1;
      rd(OFS_BYTE_TWO, v);
      chk("frozen", c32[23:16], v);
      print_verdict();
   end
endmodule // program_memory_crc_debug_regs_tb
